// ===== verilog/dcbd_consts.svh
// constants for the disk command block decoder
`ifndef DCBD_CONSTS_SVH
`define DCBD_CONSTS_SVH
`define DCBD_CMD_LEN 3'd6
`define DCBD_LAST_IDX 3'd5
`define DCBD_MAX_RETRY 4'd8
`define DCBD_CLASS_DATA 3'h0
`define DCBD_CLASS_COPY 3'h1
`define DCBD_CLASS_EXT 3'h5
`define DCBD_CLASS_PARM 3'h6
`define DCBD_CLASS_DIAG 3'h7
`define DCBD_OP_FMT_DRV 5'h04
`define DCBD_OP_CHK_FMT 5'h05
`define DCBD_OP_FMT_TRK 5'h06
`define DCBD_OP_FMT_BAD 5'h07
`define DCBD_OP_READ 5'h08
`define DCBD_OP_WRITE 5'h0A
`define DCBD_OP_ALT_TRK 5'h0E
`define DCBD_CTL_NORETRY 7
`define DCBD_CTL_NOECC 6
`define DCBD_ST_ERR 1
`define DCBD_ST_PAR 0
`define DCBD_FULL_COUNT 9'h100
`endif

// ===== verilog/dcbd_pkg.sv
// types for the disk command block decoder
package dcbd_pkg;
	typedef enum logic [2:0] {
		DCBD_IDLE,
		DCBD_CMD,
		DCBD_EXEC,
		DCBD_RETRY,
		DCBD_STATUS
	} dcbd_state_t;
	typedef enum logic [1:0] {
		DCBD_ERR_NONE,
		DCBD_ERR_SEEK,
		DCBD_ERR_DATA,
		DCBD_ERR_NOID
	} dcbd_err_t;
endpackage : dcbd_pkg

// ===== verilog/dcbd_parity.sv
// odd parity generator and checker for the host bus
`timescale 1ns/1ps
module dcbd_parity (
	input wire logic [7:0] data_i,
	input wire logic par_i,
	input wire logic par_en_i,
	output logic par_o,
	output logic par_bad_o
);
	always_comb begin
		par_o = par_en_i ? ~(^data_i) : 1'b0;
		par_bad_o = par_en_i & ~(^{data_i, par_i});
	end
endmodule : dcbd_parity

// ===== verilog/dcbd_cmd_store.sv
// six-entry store for command block bytes, registered read
`timescale 1ns/1ps
`include "dcbd_consts.svh"
module dcbd_cmd_store (
	input wire logic sys_clk_i,
	input wire logic we_i,
	input wire logic [2:0] waddr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [2:0] raddr_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem_reg [0:5];
	always_ff @(posedge sys_clk_i) begin
		if (we_i && waddr_i <= `DCBD_LAST_IDX) begin
			mem_reg[waddr_i] <= wdata_i;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		rdata_o <= (raddr_i <= `DCBD_LAST_IDX) ? mem_reg[raddr_i] : 8'h00;
	end
endmodule : dcbd_cmd_store

// ===== verilog/dcbd_top.sv
// command block decoder, retry policy and completion status
`timescale 1ns/1ps
`include "dcbd_consts.svh"
module dcbd_top
	import dcbd_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic par_en_i,
	input wire logic ext_copy_en_i,
	input wire logic sel_i,
	input wire logic cmd_byte_valid_i,
	input wire logic [7:0] cmd_byte_i,
	input wire logic cmd_par_i,
	input wire logic data_byte_valid_i,
	input wire logic [7:0] data_byte_i,
	input wire logic data_par_i,
	input wire logic [7:0] out_byte_i,
	output logic out_par_o,
	input wire logic drive_fault_i,
	input wire logic drive_not_ready_i,
	input wire logic exec_done_i,
	input wire logic exec_err_i,
	input wire dcbd_err_t exec_err_kind_i,
	input wire logic status_ack_i,
	output logic cmd_ready_o,
	output logic exec_start_o,
	output logic retry_start_o,
	output logic retry_recal_o,
	output logic [2:0] class_o,
	output logic [4:0] opcode_o,
	output logic [2:0] drive_unit_number_o,
	output logic [3:0] drive_select_o,
	output logic [20:0] sector_address_o,
	output logic [8:0] sector_count_o,
	output logic [7:0] interleave_o,
	output logic no_retry_o,
	output logic no_correct_o,
	output logic illegal_cmd_o,
	output logic status_valid_o,
	output logic [7:0] status_byte_o
);
	dcbd_state_t state_reg;
	logic [2:0] idx_reg;
	logic [3:0] retry_reg;
	logic par_err_reg;
	logic gen_err_reg;
	logic cmd_par_bad;
	logic data_par_bad;
	logic [7:0] rd_byte;
	logic [2:0] rd_idx_reg;
	logic fill_reg;
	logic last_byte;
	logic class_ok;
	logic op_ok;
	logic retryable;
	logic [7:0] ctl_reg;

	////////////////////////////////////////////////////////////////////
	dcbd_parity u_cmd_par (
		.data_i(cmd_byte_i),
		.par_i(cmd_par_i),
		.par_en_i(par_en_i),
		.par_o(),
		.par_bad_o(cmd_par_bad)
	);
	dcbd_parity u_dat_par (
		.data_i(data_byte_i),
		.par_i(data_par_i),
		.par_en_i(par_en_i),
		.par_o(),
		.par_bad_o(data_par_bad)
	);
	dcbd_parity u_out_par (
		.data_i(out_byte_i),
		.par_i(1'b0),
		.par_en_i(par_en_i),
		.par_o(out_par_o),
		.par_bad_o()
	);
	dcbd_cmd_store u_store (
		.sys_clk_i(sys_clk_i),
		.we_i(state_reg == DCBD_CMD && cmd_byte_valid_i),
		.waddr_i(idx_reg),
		.wdata_i(cmd_byte_i),
		.raddr_i(rd_idx_reg),
		.rdata_o(rd_byte)
	);

	assign cmd_ready_o = (state_reg == DCBD_CMD);
	assign last_byte = cmd_byte_valid_i && idx_reg == `DCBD_LAST_IDX;

	////////////////////////////////////////////////////////////////////
	// byte index; restarts at zero on every selection
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			idx_reg <= 3'h0;
		end else if (state_reg == DCBD_IDLE) begin
			idx_reg <= 3'h0;
		end else if (state_reg == DCBD_CMD && cmd_byte_valid_i) begin
			idx_reg <= idx_reg + 3'h1;
		end
	end

	// replay the store into decoded fields after the block is in
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rd_idx_reg <= 3'h0;
			fill_reg <= 1'b0;
		end else if (state_reg == DCBD_CMD && last_byte) begin
			rd_idx_reg <= 3'h0;
			fill_reg <= 1'b1;
		end else if (fill_reg) begin
			rd_idx_reg <= rd_idx_reg + 3'h1;
			fill_reg <= rd_idx_reg != 3'h6;
		end
	end

	// read data lags the address by one cycle
	logic [2:0] fld_idx_reg;
	logic fld_ok_reg;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			fld_idx_reg <= 3'h0;
			fld_ok_reg <= 1'b0;
		end else begin
			fld_idx_reg <= rd_idx_reg;
			fld_ok_reg <= fill_reg && rd_idx_reg <= `DCBD_LAST_IDX;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			class_o <= 3'h0;
			opcode_o <= 5'h00;
			drive_unit_number_o <= 3'h0;
			sector_address_o <= 21'h000000;
			ctl_reg <= 8'h00;
			sector_count_o <= 9'h000;
			interleave_o <= 8'h00;
		end else if (fld_ok_reg) begin
			case (fld_idx_reg)
				3'h0: begin
					class_o <= rd_byte[7:5];
					opcode_o <= rd_byte[4:0];
				end
				3'h1: begin
					drive_unit_number_o <= rd_byte[7:5];
					sector_address_o[20:16] <= rd_byte[4:0];
				end
				3'h2: sector_address_o[15:8] <= rd_byte;
				3'h3: sector_address_o[7:0] <= rd_byte;
				3'h4: begin
					sector_count_o <= (rd_byte == 8'h00) ?
						`DCBD_FULL_COUNT : {1'b0, rd_byte};
					interleave_o <= (rd_byte == 8'h00) ?
						8'h01 : rd_byte;
				end
				default: ctl_reg <= rd_byte;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	logic is_rw;
	logic uses_ctl;
	always_comb begin
		is_rw = class_o == `DCBD_CLASS_DATA &&
			(opcode_o == `DCBD_OP_READ || opcode_o == `DCBD_OP_WRITE);
		uses_ctl = is_rw || (class_o == `DCBD_CLASS_DATA &&
			opcode_o == `DCBD_OP_ALT_TRK);
		no_retry_o = uses_ctl & ctl_reg[`DCBD_CTL_NORETRY];
		no_correct_o = uses_ctl & ctl_reg[`DCBD_CTL_NOECC];
		drive_select_o = 4'h1 << drive_unit_number_o[1:0];
		if (drive_unit_number_o[2]) begin
			drive_select_o = 4'h0;
		end
		case (class_o)
			`DCBD_CLASS_DATA: class_ok = 1'b1;
			`DCBD_CLASS_COPY: class_ok = 1'b1;
			`DCBD_CLASS_PARM: class_ok = 1'b1;
			`DCBD_CLASS_DIAG: class_ok = 1'b1;
			`DCBD_CLASS_EXT: class_ok = ext_copy_en_i;
			default: class_ok = 1'b0;
		endcase
		op_ok = class_ok && !drive_unit_number_o[2];
		illegal_cmd_o = !op_ok;
		retryable = !no_retry_o && (
			(is_rw && exec_err_kind_i == DCBD_ERR_SEEK) ||
			(is_rw && opcode_o == `DCBD_OP_READ &&
			exec_err_kind_i == DCBD_ERR_DATA)) &&
			exec_err_kind_i != DCBD_ERR_NOID;
	end

	////////////////////////////////////////////////////////////////////
	// the control byte lands one cycle after the last field read, so
	// go or abort waits a cycle; status shows once the flags settle
	logic decode_done;
	logic stat_ok_reg;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			decode_done <= 1'b0;
			stat_ok_reg <= 1'b0;
		end else begin
			decode_done <= fld_ok_reg && fld_idx_reg == `DCBD_LAST_IDX;
			stat_ok_reg <= state_reg == DCBD_STATUS;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_reg <= DCBD_IDLE;
		end else begin
			case (state_reg)
				DCBD_IDLE: begin
					if (sel_i) begin
						state_reg <= DCBD_CMD;
					end
				end
				DCBD_CMD: begin
					if (last_byte) begin
						state_reg <= DCBD_EXEC;
					end
				end
				DCBD_EXEC: begin
					if (decode_done && (par_err_reg || illegal_cmd_o ||
						drive_fault_i || drive_not_ready_i)) begin
						state_reg <= DCBD_STATUS;
					end else if (exec_err_i && retryable &&
						retry_reg != `DCBD_MAX_RETRY) begin
						state_reg <= DCBD_RETRY;
					end else if (exec_err_i || exec_done_i) begin
						state_reg <= DCBD_STATUS;
					end
				end
				DCBD_RETRY: state_reg <= DCBD_EXEC;
				default: begin
					if (status_ack_i && status_valid_o) begin
						state_reg <= DCBD_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			retry_reg <= 4'h0;
		end else if (state_reg == DCBD_IDLE) begin
			retry_reg <= 4'h0;
		end else if (state_reg == DCBD_RETRY) begin
			retry_reg <= retry_reg + 4'h1;
		end
	end

	assign exec_start_o = decode_done && state_reg == DCBD_EXEC &&
		!(par_err_reg || illegal_cmd_o || drive_fault_i ||
		drive_not_ready_i);
	assign retry_start_o = state_reg == DCBD_RETRY;
	assign retry_recal_o = retry_start_o &&
		exec_err_kind_i == DCBD_ERR_SEEK;

	// error flags clear only when a new command is selected
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			par_err_reg <= 1'b0;
		end else if (state_reg == DCBD_IDLE && sel_i) begin
			par_err_reg <= 1'b0;
		end else if ((state_reg == DCBD_CMD && cmd_byte_valid_i &&
			cmd_par_bad) || (state_reg == DCBD_EXEC &&
			data_byte_valid_i && data_par_bad)) begin
			par_err_reg <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			gen_err_reg <= 1'b0;
		end else if (state_reg == DCBD_IDLE && sel_i) begin
			gen_err_reg <= 1'b0;
		end else if (state_reg == DCBD_EXEC) begin
			if (decode_done && (illegal_cmd_o || drive_fault_i ||
				drive_not_ready_i)) begin
				gen_err_reg <= 1'b1;
			end else if (exec_err_i && !(retryable &&
				retry_reg != `DCBD_MAX_RETRY)) begin
				gen_err_reg <= 1'b1;
			end
		end
	end

	assign status_valid_o = state_reg == DCBD_STATUS && stat_ok_reg;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			status_byte_o <= 8'h00;
		end else begin
			status_byte_o <= {drive_unit_number_o, 3'b000,
				gen_err_reg, par_err_reg};
		end
	end

	////////////////////////////////////////////////////////////////////
	sequence retry_go_s;
		state_reg == DCBD_RETRY;
	endsequence
	sequence back_exec_s;
		##1 state_reg == DCBD_EXEC;
	endsequence

	retry_count_cap_a: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i) retry_go_s |-> retry_reg < `DCBD_MAX_RETRY)
		else $error("more than eight retries");
	retry_returns_a: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i) retry_go_s |-> back_exec_s)
		else $error("retry did not resume execution");
	no_retry_set_a: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i) no_retry_o |-> !retryable)
		else $error("retry allowed while disabled");
	spare_zero_a: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i) status_valid_o |-> status_byte_o[4:2] == 3'b000)
		else $error("status spare bits not zero");
	par_flag_a: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i) (state_reg == DCBD_CMD && cmd_byte_valid_i &&
		cmd_par_bad) |=> par_err_reg)
		else $error("parity error not flagged");
	abort_status_a: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i) (state_reg == DCBD_EXEC && exec_err_i &&
		!retryable) |=> state_reg == DCBD_STATUS)
		else $error("error did not abort to status");
	status_unit_a: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i) status_valid_o && $stable(drive_unit_number_o)
		|-> status_byte_o[7:5] == drive_unit_number_o)
		else $error("status unit number wrong");
	count_zero_a: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i) (fld_ok_reg && fld_idx_reg == 3'h4 &&
		rd_byte == 8'h00) |=> sector_count_o == `DCBD_FULL_COUNT)
		else $error("zero count not 256");
	status_end_a: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i) (status_valid_o && status_ack_i) |=>
		state_reg == DCBD_IDLE)
		else $error("status phase did not end");
endmodule : dcbd_top

// ===== tb/dcbd_host_model.sv
// host adapter model: selection, command block bytes, status acknowledge
`timescale 1ns/1ps
module dcbd_host_model (
	input wire logic clk_i,
	input wire logic cmd_ready_i,
	output logic sel_o,
	output logic valid_o,
	output logic [7:0] byte_o,
	output logic par_o,
	output logic ack_o
);
	initial begin
		sel_o = 1'b0;
		valid_o = 1'b0;
		byte_o = 8'h00;
		par_o = 1'b0;
		ack_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// bad names the byte whose parity is flipped; 6 or more flips none
	task send(input logic [7:0] b [6], input int bad);
		int n;
		n = 0;
		@(posedge clk_i);
		sel_o <= 1'b1;
		do begin
			@(negedge clk_i);
			n++;
		end while (cmd_ready_i !== 1'b1 && n < 50);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_i);
			sel_o <= 1'b0;
			valid_o <= 1'b1;
			byte_o <= b[i];
			par_o <= ~^b[i] ^ (i == bad);
		end
		@(posedge clk_i);
		valid_o <= 1'b0;
		// released bus shows the inverse, not the last byte
		byte_o <= ~byte_o;
		par_o <= ~par_o;
	endtask : send

	task ack();
		@(posedge clk_i);
		ack_o <= 1'b1;
		@(posedge clk_i);
		ack_o <= 1'b0;
	endtask : ack
endmodule : dcbd_host_model

// ===== tb/dcbd_top_test.sv
// self-checking bench for the command block decoder
`timescale 1ns/1ps
`include "dcbd_consts.svh"
module dcbd_top_test
	import dcbd_pkg::*;
;
	logic sys_clk_i, rst_n_i, par_en_i, ext_copy_en_i, sel_i, cmd_byte_valid_i;
	logic cmd_par_i, data_byte_valid_i, data_par_i, drive_fault_i;
	logic drive_not_ready_i, exec_done_i, exec_err_i, status_ack_i;
	logic [7:0] cmd_byte_i, data_byte_i, out_byte_i, interleave_o, status_byte_o;
	dcbd_err_t exec_err_kind_i;
	logic out_par_o, cmd_ready_o, exec_start_o, retry_start_o, retry_recal_o;
	logic no_retry_o, no_correct_o, illegal_cmd_o, status_valid_o;
	logic [2:0] class_o, drive_unit_number_o;
	logic [4:0] opcode_o;
	logic [3:0] drive_select_o;
	logic [20:0] sector_address_o;
	logic [8:0] sector_count_o;
	int bad_count = 0;
	int num_checks = 0;
	int cyc = 0;

	dcbd_top dut_u (.sys_clk_i, .rst_n_i, .par_en_i, .ext_copy_en_i, .sel_i,
		.cmd_byte_valid_i, .cmd_byte_i, .cmd_par_i, .data_byte_valid_i,
		.data_byte_i, .data_par_i, .out_byte_i, .out_par_o, .drive_fault_i,
		.drive_not_ready_i, .exec_done_i, .exec_err_i, .exec_err_kind_i,
		.status_ack_i, .cmd_ready_o, .exec_start_o, .retry_start_o,
		.retry_recal_o, .class_o, .opcode_o, .drive_unit_number_o,
		.drive_select_o, .sector_address_o, .sector_count_o, .interleave_o,
		.no_retry_o, .no_correct_o, .illegal_cmd_o, .status_valid_o,
		.status_byte_o);

	dcbd_host_model host_u (.clk_i(sys_clk_i), .cmd_ready_i(cmd_ready_o),
		.sel_o(sel_i), .valid_o(cmd_byte_valid_i), .byte_o(cmd_byte_i),
		.par_o(cmd_par_i), .ack_o(status_ack_i));

	////////////////////////////////////////////////////////////////////////
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : check

	task conclude();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////
	// bad: 0-5 command byte parity flipped, 6 data byte flipped, 7 clean
	task run(input logic [2:0] cl, input logic [4:0] op, input logic [2:0] un,
		input logic [20:0] ad, input logic [7:0] b4, input logic [7:0] b5,
		input int bad, input int nerr, input dcbd_err_t kd);
		logic [7:0] b [6];
		logic [7:0] d;
		logic ilg, xp, xe, ex, rt;
		int n, r, rc, xr;
		b = '{{cl, op}, {un, ad[20:16]}, ad[15:8], ad[7:0], b4, b5};
		host_u.send(b, bad);
		ilg = cl inside {3'h2, 3'h3, 3'h4} || (cl == 3'h5 && !ext_copy_en_i) || un > 3;
		xp = par_en_i && bad < 7;
		rt = !b5[7] && cl == 3'h0 && ((kd == DCBD_ERR_SEEK &&
			(op == `DCBD_OP_READ || op == `DCBD_OP_WRITE)) ||
			(kd == DCBD_ERR_DATA && op == `DCBD_OP_READ));
		xr = rt ? (nerr > 8 ? 8 : nerr) : 0;
		ex = !(xp && bad < 6) && !ilg && !drive_fault_i && !drive_not_ready_i;
		xe = !(xp && bad < 6) && (!ex || nerr > xr);
		n = 0;
		do begin
			@(negedge sys_clk_i);
			n++;
		end while (!(exec_start_o || status_valid_o) && n < 60);
		check("start", exec_start_o, ex);
		if (bad > 5) begin
			check("class", class_o, cl);
			check("opcode", opcode_o, op);
			check("unit", drive_unit_number_o, un);
			check("select", drive_select_o, un < 4 ? 4'h1 << un : 4'h0);
			check("address", sector_address_o, ad);
			check("illegal", illegal_cmd_o, ilg);
			if (op == `DCBD_OP_READ || op == `DCBD_OP_WRITE) begin
				check("count", sector_count_o, b4 == 0 ? 256 : b4);
				check("noretry", no_retry_o, b5[7]);
				check("nocorrect", no_correct_o, b5[6]);
			end else if (op[4:2] == 3'h1 || op == `DCBD_OP_ALT_TRK)
				check("interleave", interleave_o, b4 < 2 ? 1 : b4);
		end
		r = 0;
		rc = 0;
		if (exec_start_o === 1'b1) begin
			d = 8'($urandom);
			@(posedge sys_clk_i);
			data_byte_valid_i <= 1'b1;
			data_byte_i <= d;
			data_par_i <= ~^d ^ (bad == 6);
			@(posedge sys_clk_i);
			data_byte_valid_i <= 1'b0;
			data_byte_i <= ~d;
			for (int i = 0; i < nerr && status_valid_o !== 1'b1; i++) begin
				@(posedge sys_clk_i);
				exec_err_i <= 1'b1;
				exec_err_kind_i <= kd;
				@(posedge sys_clk_i);
				exec_err_i <= 1'b0;
				n = 0;
				do begin
					@(negedge sys_clk_i);
					n++;
				end while (!(retry_start_o || status_valid_o) && n < 60);
				r += retry_start_o;
				rc += retry_recal_o;
			end
			if (status_valid_o !== 1'b1) begin
				@(posedge sys_clk_i);
				exec_done_i <= 1'b1;
				@(posedge sys_clk_i);
				exec_done_i <= 1'b0;
			end
		end
		n = 0;
		while (status_valid_o !== 1'b1 && n < 60) begin
			@(negedge sys_clk_i);
			n++;
		end
		check("retries", r, xr);
		check("recals", rc, kd == DCBD_ERR_SEEK ? xr : 0);
		check("valid", status_valid_o, 1);
		check("status", status_byte_o, {un, 3'b000, xe, xp});
		host_u.ack();
	endtask : run

	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			conclude();
		end
	end

	initial begin
		{rst_n_i, par_en_i, ext_copy_en_i, data_byte_valid_i, data_par_i} = '0;
		{drive_fault_i, drive_not_ready_i, exec_done_i, exec_err_i} = '0;
		data_byte_i = 8'h00;
		out_byte_i = 8'h00;
		exec_err_kind_i = DCBD_ERR_NONE;
		void'($urandom(96504));
		repeat (12) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		par_en_i <= 1'b1;
		// commands follow each other, errored or not
		for (int i = 0; i < 12; i++) begin
			@(posedge sys_clk_i);
			out_byte_i <= 8'($urandom);
			@(negedge sys_clk_i);
			check("outpar", out_par_o, ~^out_byte_i);
			run(3'h0, i[0] ? `DCBD_OP_READ : `DCBD_OP_WRITE, 3'($urandom % 4),
				21'($urandom), 8'($urandom), 8'($urandom), 7, $urandom % 3,
				i[1] ? DCBD_ERR_SEEK : DCBD_ERR_DATA);
		end
		run(3'h0, `DCBD_OP_READ, 3'h1, 21'h1FFFFF, 8'h00, 8'h00, 7, 0, DCBD_ERR_NONE);
		run(3'h0, `DCBD_OP_ALT_TRK, 3'h3, 21'h000001, 8'h00, 8'h00, 7, 0,
			DCBD_ERR_NONE);
		for (int c = 1; c < 16; c++) begin
			@(posedge sys_clk_i);
			ext_copy_en_i <= c[3];
			run(c[2:0], 5'h00, 3'h0, 21'h0, 8'h00, 8'h00, 7, 0, DCBD_ERR_NONE);
		end
		run(3'h0, `DCBD_OP_READ, 3'h5, 21'h0, 8'h01, 8'h00, 7, 0, DCBD_ERR_NONE);
		for (int f = 0; f < 2; f++) begin
			@(posedge sys_clk_i);
			{drive_fault_i, drive_not_ready_i} <= f ? 2'b01 : 2'b10;
			run(3'h0, `DCBD_OP_WRITE, 3'h2, 21'h0, 8'h01, 8'h00, 7, 0,
				DCBD_ERR_NONE);
			{drive_fault_i, drive_not_ready_i} <= 2'b00;
		end
		run(3'h0, `DCBD_OP_READ, 3'h2, 21'h0ABCDE, 8'h01, 8'h00, 7, 8, DCBD_ERR_SEEK);
		run(3'h0, `DCBD_OP_WRITE, 3'h2, 21'h0ABCDE, 8'h01, 8'h00, 7, 9,
			DCBD_ERR_SEEK);
		run(3'h0, `DCBD_OP_READ, 3'h0, 21'h012345, 8'h02, 8'h00, 7, 9, DCBD_ERR_DATA);
		run(3'h0, `DCBD_OP_READ, 3'h0, 21'h012345, 8'h02, 8'h80, 7, 1, DCBD_ERR_SEEK);
		run(3'h0, `DCBD_OP_CHK_FMT, 3'h1, 21'h0, 8'h01, 8'h00, 7, 1,
			DCBD_ERR_NOID);
		run(3'h0, `DCBD_OP_READ, 3'h3, 21'h0, 8'h01, 8'h00, 2, 0, DCBD_ERR_NONE);
		run(3'h0, `DCBD_OP_WRITE, 3'h1, 21'h0, 8'h01, 8'h00, 6, 0, DCBD_ERR_NONE);
		@(posedge sys_clk_i);
		par_en_i <= 1'b0;
		@(negedge sys_clk_i);
		check("outpar", out_par_o, 1'b0);
		run(3'h0, `DCBD_OP_READ, 3'h0, 21'h0, 8'h01, 8'h00, 0, 0, DCBD_ERR_NONE);
		conclude();
	end
endmodule : dcbd_top_test
